// ===== shared/pvc_pkg.sv
// package for the phy vendor-specific configuration register
package pvc_pkg;
  localparam logic [4:0]  VSC_ADDR      = 5'h10;
  localparam logic [15:0] VSC_RESET     = 16'h0140;
  localparam logic [15:0] VSC_RSVD_MASK = 16'h23cc;
  localparam int          REPEAT_BIT    = 15;
  localparam int          IRQPOL_BIT    = 14;
  localparam int          TXHZ_BIT      = 12;
  localparam int          HBEAT_BIT     = 11;
  localparam int          NATLOOP_BIT   = 10;
  localparam int          APD_BIT       = 5;
  localparam int          RVP_BIT       = 4;
  localparam int          CSB_BIT       = 1;
  localparam int          RCG_BIT       = 0;
endpackage : pvc_pkg

// ===== rtl/pvc_vendor_config.sv
// vendor-specific configuration register and the controls it drives
// Overview of operation
// (R1) register at management index 0x10, 16 bits, reset value 0x0140
// (R2) auto-polarity disable bit 5 turns off automatic polarity correction
// (R3) auto-polarity enabled at 10 Mb/s inverts receive on reversed pair
// (R4) with auto-polarity on, bit 4 is read-only inversion status
// (R5) with auto-polarity off, bit 4 is writable and forces inversion
// (R6) host preserves reserved bits on read-modify-write and ignores them
// (R7) bypass bit 1 skips coding sublayer and scrambler at 100BASE-TX
// (R8) host enables bypass only with autoneg off and 100 Mb/s forced
// (R9) gating bit 0 enables receive clock gating only at 100BASE-TX
// (R10) gated receive clock stops while idle and runs during reception
// (R11) host should not enable gating together with coding bypass
// (R12) loopback in basic control register suspends receive clock gating
// (R13) bit 14 selects interrupt polarity, one is active high
// (R14) bit 12 puts both transmitter outputs into high impedance
// (R15) bit 10 at 10 Mb/s loops transmit data back to receive
module pvc_vendor_config
  import pvc_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  // management register access
  input  wire logic [4:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic [15:0] REG_WDATA_I,
  output logic      [15:0] REG_RDATA_O,
  // phy status from the rest of the transceiver
  input  wire logic        SPEED_100_I,
  input  wire logic        LOOPBACK_SELECT_I,
  input  wire logic        POLARITY_REVERSED_I,
  input  wire logic        RX_ACTIVE_I,
  input  wire logic        IRQ_RAW_I,
  // controls out
  output logic             RX_INVERT_O,
  output logic             CODING_BYPASS_O,
  output logic             RX_CLK_EN_O,
  output logic             IRQ_O,
  output logic             TX_HIGH_Z_O,
  output logic             NATURAL_LOOPBACK_O,
  output logic             REPEATER_SELECT_O,
  output logic             HEARTBEAT_INHIBIT_O
);

  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic        pol_r;
  logic        pol_nxt;
  logic [15:0] rdata_nxt;

  // status inputs are from the same clock domain
  wire         sel_w     = (REG_ADDR_I == VSC_ADDR); // [R1]
  wire         wr_w      = REG_WR_I & sel_w;
  wire         apd_w     = cfg_r[APD_BIT];
  // auto detection only meaningful at 10 Mb/s
  wire         auto_pol_w = ~apd_w & ~SPEED_100_I & POLARITY_REVERSED_I; // [R2] [R3]
  wire         gate_w    = cfg_r[RCG_BIT] & SPEED_100_I & ~LOOPBACK_SELECT_I; // [R9] [R12]

  // reserved bits keep their reset value whatever is written
  assign cfg_nxt = wr_w ? ((REG_WDATA_I & ~VSC_RSVD_MASK) | (VSC_RESET & VSC_RSVD_MASK))
                        : cfg_r;
  // forced polarity only from a write while auto-polarity is off
  assign pol_nxt = apd_w ? (wr_w ? REG_WDATA_I[RVP_BIT] : pol_r) : auto_pol_w; // [R4] [R5]

  always_comb begin
    rdata_nxt          = cfg_r;
    rdata_nxt[RVP_BIT] = pol_r; // [R4]
    if (!sel_w) begin
      rdata_nxt = 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cfg_r <= VSC_RESET; // [R1]
      pol_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      pol_r <= pol_nxt;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O         <= 16'h0000;
      RX_INVERT_O         <= 1'b0;
      CODING_BYPASS_O     <= 1'b0;
      RX_CLK_EN_O         <= 1'b1;
      IRQ_O               <= 1'b1;
      TX_HIGH_Z_O         <= 1'b0;
      NATURAL_LOOPBACK_O  <= 1'b0;
      REPEATER_SELECT_O   <= 1'b0;
      HEARTBEAT_INHIBIT_O <= 1'b0;
    end else begin
      REG_RDATA_O         <= rdata_nxt;
      RX_INVERT_O         <= pol_nxt; // [R3] [R5]
      CODING_BYPASS_O     <= cfg_nxt[CSB_BIT] & SPEED_100_I; // [R7]
      RX_CLK_EN_O         <= ~gate_w | RX_ACTIVE_I; // [R10]
      IRQ_O               <= IRQ_RAW_I ~^ cfg_r[IRQPOL_BIT]; // [R13]
      TX_HIGH_Z_O         <= cfg_nxt[TXHZ_BIT]; // [R14]
      NATURAL_LOOPBACK_O  <= cfg_nxt[NATLOOP_BIT] & ~SPEED_100_I; // [R15]
      REPEATER_SELECT_O   <= cfg_nxt[REPEAT_BIT];
      HEARTBEAT_INHIBIT_O <= cfg_nxt[HBEAT_BIT];
    end
  end

  property p_reset_value;
    @(posedge REF_CLK_I) $rose(RESETN_I) |-> cfg_r == VSC_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value"); // [R1]

  property p_auto_off;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      apd_w && !wr_w |=> RX_INVERT_O == $past(pol_r);
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto polarity not off"); // [R2]

  property p_auto_inv;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      !apd_w && !SPEED_100_I && POLARITY_REVERSED_I |=> RX_INVERT_O;
  endproperty
  a_auto_inv: assert property (p_auto_inv) else $error("no auto inversion"); // [R3]

  property p_ro_status;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      !apd_w |=> pol_r == $past(auto_pol_w);
  endproperty
  a_ro_status: assert property (p_ro_status) else $error("status bit wrong"); // [R4]

  property p_force;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_w && apd_w |=> pol_r == $past(REG_WDATA_I[RVP_BIT]);
  endproperty
  a_force: assert property (p_force) else $error("forced polarity lost"); // [R5]

  property p_bypass;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      CODING_BYPASS_O |-> cfg_r[CSB_BIT] && $past(SPEED_100_I);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass outside 100 mode"); // [R7]

  property p_gate;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      !RX_CLK_EN_O |-> $past(cfg_r[RCG_BIT] && SPEED_100_I && !RX_ACTIVE_I);
  endproperty
  a_gate: assert property (p_gate) else $error("clock stopped wrongly"); // [R9] [R10]

  property p_loop;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      LOOPBACK_SELECT_I |=> RX_CLK_EN_O;
  endproperty
  a_loop: assert property (p_loop) else $error("gating during loopback"); // [R12]

  property p_irq;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      IRQ_RAW_I && !cfg_r[IRQPOL_BIT] && !wr_w |=> !IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("irq polarity wrong"); // [R13]

  property p_hz;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      TX_HIGH_Z_O == cfg_r[TXHZ_BIT];
  endproperty
  a_hz: assert property (p_hz) else $error("high z mismatch"); // [R14]

  property p_nl;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      NATURAL_LOOPBACK_O |-> cfg_r[NATLOOP_BIT] && $past(!SPEED_100_I);
  endproperty
  a_nl: assert property (p_nl) else $error("natural loopback wrong"); // [R15]

  property p_nl_on;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_w && REG_WDATA_I[NATLOOP_BIT] && !SPEED_100_I |=> NATURAL_LOOPBACK_O;
  endproperty
  a_nl_on: assert property (p_nl_on) else $error("natural loopback not set"); // [R15]

  // a write lands on every writable bit; reserved bits never move
  property p_write_lands;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_w |=> (cfg_r & ~VSC_RSVD_MASK) == ($past(REG_WDATA_I) & ~VSC_RSVD_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost"); // [R1]

  property p_rsvd_read;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      sel_w |=> (REG_RDATA_O & VSC_RSVD_MASK) == (VSC_RESET & VSC_RSVD_MASK);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits moved"); // [R1]

  property p_other_read;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      !sel_w |=> REG_RDATA_O == 16'h0000;
  endproperty
  a_other_read: assert property (p_other_read) else $error("foreign index answered"); // [R1]

  property p_pol_read;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      sel_w |=> REG_RDATA_O[RVP_BIT] == $past(pol_r);
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity read wrong"); // [R4] [R5]

  property p_bypass_on;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_w && REG_WDATA_I[CSB_BIT] && SPEED_100_I |=> CODING_BYPASS_O;
  endproperty
  a_bypass_on: assert property (p_bypass_on) else $error("bypass not set"); // [R7]

  property p_gate_stop;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      cfg_r[RCG_BIT] && SPEED_100_I && !LOOPBACK_SELECT_I && !RX_ACTIVE_I |=> !RX_CLK_EN_O;
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("idle clock not gated"); // [R10]

  property p_gate_run;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      RX_ACTIVE_I |=> RX_CLK_EN_O;
  endproperty
  a_gate_run: assert property (p_gate_run) else $error("clock gated in reception"); // [R10]

  property p_irq_high;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      IRQ_RAW_I && cfg_r[IRQPOL_BIT] |=> IRQ_O;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("active high irq missing"); // [R13]

  property p_hz_wr;
    @(posedge REF_CLK_I) disable iff (!RESETN_I)
      wr_w |=> TX_HIGH_Z_O == $past(REG_WDATA_I[TXHZ_BIT]);
  endproperty
  a_hz_wr: assert property (p_hz_wr) else $error("high z not written"); // [R14]

endmodule : pvc_vendor_config

// ===== sim/pvc_host.sv
// management host model: read-modify-write of the vendor register
module pvc_host
  import pvc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] val_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_o,
  output logic      [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // gating dropped when bypass asked for; reserved bits copied from last read
  always_ff @(posedge clk_i) begin
    wr_o    <= go_i;
    wdata_o <= (val_i & ~VSC_RSVD_MASK & ~{15'h0, val_i[1]})
               | (rdata_i & VSC_RSVD_MASK);
  end
endmodule : pvc_host

// ===== sim/testbench.sv
// self-checking bench for the vendor configuration register
module testbench
  import pvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, look = 1'b0;
  logic spd = 1'b0, lb = 1'b0, pol = 1'b0, rxa = 1'b0, raw = 1'b0, wr;
  logic [4:0] addr = 5'h10;
  logic [15:0] val = 16'h0, wd, rd;
  logic [7:0] o;
  logic [23:0] q[$];
  logic [23:0] e;
  int seed = 32'h6d7b6b73, mismatches = 0, checked = 0;
  always #4 clk = ~clk;
  pvc_host host_u (.clk_i(clk), .go_i(go), .val_i(val), .rdata_i(rd), .wr_o(wr), .wdata_o(wd));
  pvc_vendor_config dut_u (.REF_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RDATA_O(rd), .SPEED_100_I(spd),
    .LOOPBACK_SELECT_I(lb), .POLARITY_REVERSED_I(pol), .RX_ACTIVE_I(rxa), .IRQ_RAW_I(raw),
    .RX_INVERT_O(o[7]), .CODING_BYPASS_O(o[6]), .RX_CLK_EN_O(o[5]), .IRQ_O(o[4]),
    .TX_HIGH_Z_O(o[3]), .NATURAL_LOOPBACK_O(o[2]), .REPEATER_SELECT_O(o[1]),
    .HEARTBEAT_INHIBIT_O(o[0]));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // one entry per step: outputs derived from expected register and inputs
  task automatic step(input logic [4:0] a, input logic [15:0] v, input logic s, input logic l,
                      input logic p, input logic [15:0] x, input logic w);
    logic r, k;
    r = 1'($random(seed));
    k = 1'($random(seed));
    addr <= a; val <= v; spd <= s; lb <= l; pol <= p; raw <= r; rxa <= k; go <= w;
    @(posedge clk) go <= 1'b0;
    repeat (4) @(posedge clk);
    q.push_back({(a == VSC_ADDR) ? x : 16'h0, x[4], x[1] & s, !(x[0] & s & !l) | k,
                 x[14] ? r : !r, x[12], x[10] & !s, x[15], x[11]});
    look <= 1'b1;
    @(posedge clk) look <= 1'b0;
  endtask : step
  // watcher: oldest note against what the outputs show
  always @(negedge clk) begin
    if (look) begin
      e = q.pop_front();
      chk({8'h0, rd}, {8'h0, e[23:8]});
      chk({21'h0, o[7:5]}, {21'h0, e[7:5]});
      chk({19'h0, o[4:0]}, {19'h0, e[4:0]});
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    step(5'h10, 16'h0000, 0, 0, 0, 16'h0140, 0);
    step(5'h10, 16'h0020, 0, 0, 0, 16'h0160, 1);
    step(5'h10, 16'h0030, 0, 0, 1, 16'h0170, 1);
    step(5'h10, 16'h0020, 0, 0, 1, 16'h0160, 1);
    step(5'h10, 16'h0000, 0, 0, 1, 16'h0150, 1);
    step(5'h10, 16'h0010, 0, 0, 0, 16'h0140, 1);
    // bypass only ever requested at 100 Mb/s
    step(5'h10, 16'h5c02, 1, 0, 0, 16'h5d42, 1);
    step(5'h10, 16'h8401, 1, 0, 0, 16'h8541, 1);
    step(5'h10, 16'h8401, 1, 1, 0, 16'h8541, 1);
    step(5'h10, 16'hffff, 1, 0, 0, 16'hdd62, 1);
    step(5'h11, 16'h0000, 1, 0, 0, 16'hdd62, 1);
    // natural loopback only acts at 10 Mb/s
    step(5'h10, 16'h0400, 0, 0, 1, 16'h0550, 1);
    repeat (2) @(posedge clk);
    if (q.size() != 0) mismatches++;
    results();
  end
endmodule : testbench
